//--- rmc_regs.vh
// Register map, field positions, reset values and timing figures of the mode controller.
`ifndef RMC_REGS_VH
`define RMC_REGS_VH
`define RMC_ADDR_DEV_STATUS 7'h02
`define RMC_ADDR_IRQ_ST1    7'h03
`define RMC_ADDR_IRQ_ST2    7'h04
`define RMC_ADDR_IRQ_EN1    7'h05
`define RMC_ADDR_IRQ_EN2    7'h06
`define RMC_ADDR_MODE       7'h07
`define RMC_ADDR_MODE2      7'h08
`define RMC_ADDR_XTAL_CTL   7'h62
`define RMC_RST_IRQ_EN1     8'h00
`define RMC_RST_IRQ_EN2     8'h01
`define RMC_RST_MODE        8'h01
`define RMC_RST_MODE2       8'h01
`define RMC_RST_XTAL_CTL    8'h00
`define RMC_MODE_SWRES      7
`define RMC_MODE_ENWT       6
`define RMC_MODE_ENLBD      5
`define RMC_MODE_RXON       2
`define RMC_MODE_PLLON      1
`define RMC_MODE_XTON       0
`define RMC_MODE_WMASK      8'h67
`define RMC_MODE2_VCOCAL    0
`define RMC_MODE2_ENTEMP    1
`define RMC_MODE2_WMASK     8'h03
`define RMC_XTAL_BUFOVR     1
`define RMC_IRQ1_MASK       8'h99
`define RMC_CPS_IDLE        2'h0
`define RMC_CPS_RX          2'h1
`define RMC_CLK_MHZ         100
`define RMC_POR_US          16600
`define RMC_XTAL_US         600
`define RMC_CAL_US          100
`define RMC_SETTLE_US       100
`endif

//--- rmc_sync.v
// Two-stage synchroniser for pins that arrive from outside the clock domain.
`timescale 1ns/100ps
module rmc_sync #(
  parameter         W       = 1,
  parameter [W-1:0] RST_VAL = {W{1'b0}}
) (
  input  wire         clk,
  input  wire         sys_rst,
  input  wire [W-1:0] din,
  output wire [W-1:0] dout
);
  reg [W-1:0] metaFf;
  reg [W-1:0] syncFf;

  // Only the second stage is visible outside.
  always @(posedge clk) begin
    if (sys_rst) begin
      metaFf <= RST_VAL;
      syncFf <= RST_VAL;
    end else begin
      metaFf <= din;
      syncFf <= metaFf;
    end
  end

  assign dout = syncFf;
endmodule // rmc_sync

//--- rmc_spi_slave.v
// Serial register port: 16-bit frames with burst auto-increment.
`timescale 1ns/100ps
module rmc_spi_slave (
  input  wire       clk,
  input  wire       rst,
  input  wire       sclkS,
  input  wire       sdiS,
  input  wire       selNS,
  input  wire [7:0] rdData,
  output wire [6:0] rdAddr,
  output wire       rdStb,
  output wire       wrStb,
  output wire [6:0] wrAddr,
  output wire [7:0] wrData,
  output wire       sdo,
  output wire       sdoOe
);
  reg       sclkDlyFf;
  reg [3:0] cntFf;
  reg [7:0] shFf;
  reg [7:0] outShFf;
  reg [6:0] addrFf;
  reg       wrFf;
  reg       sdoFf;

  wire       active   = ~rst & ~selNS;
  wire       rise     = active & sclkS & ~sclkDlyFf;
  wire       fall     = active & ~sclkS & sclkDlyFf;
  wire [7:0] nxtSh    = {shFf[6:0], sdiS};
  wire       hdrDone  = rise & (cntFf == 4'h7);
  wire       byteDone = rise & (cntFf == 4'hF);

  // Burst reads fetch the next register ahead, so a read-clear register
  // placed right after the last one read is cleared as well.
  assign rdStb  = (hdrDone & ~nxtSh[7]) | (byteDone & ~wrFf);
  assign rdAddr = hdrDone ? nxtSh[6:0] : addrFf + 7'h01;
  assign wrStb  = byteDone & wrFf;
  assign wrAddr = addrFf;
  assign wrData = nxtSh;
  assign sdo    = sdoFf;
  assign sdoOe  = active;

  always @(posedge clk) begin
    if (rst) begin
      sclkDlyFf <= 1'b0;
    end else begin
      sclkDlyFf <= sclkS;
    end
  end

  always @(posedge clk) begin
    if (rst | selNS) begin
      cntFf   <= 4'h0;
      shFf    <= 8'h00;
      outShFf <= 8'h00;
      addrFf  <= 7'h00;
      wrFf    <= 1'b0;
      sdoFf   <= 1'b1;
    end else if (rise) begin
      shFf  <= nxtSh;
      cntFf <= (cntFf == 4'hF) ? 4'h8 : cntFf + 4'h1;
      if (hdrDone) begin
        addrFf <= nxtSh[6:0];
        wrFf   <= nxtSh[7];
      end
      if (byteDone) begin
        addrFf <= addrFf + 7'h01;
      end
      if (rdStb) begin
        outShFf <= rdData;
      end
    end else if (fall) begin
      sdoFf   <= outShFf[7];
      outShFf <= {outShFf[6:0], 1'b0};
    end
  end
endmodule // rmc_spi_slave

//--- rmc_mode_ctrl.v
// Operating-mode sequencer, register file and interrupt logic of the receiver.
//
// Contract
// - Shutdown, idle and receive; five idle sub-modes.
// - Mode register selects mode; pin governs shutdown.
// - Receive-on in idle starts receive automatically.
// - Main regulator off only in standby, sleep; code keeps it on there until status read after power-on reset.
// - Receive reached in 16.8 ms, 800 or 200 us; from shutdown the code takes at least 17.4 ms.
// - Pin high: shutdown, registers lost, serial refused.
// - Pin falling edge starts power-on reset.
// - Reset, soft reset, shutdown exit give ready.
// - Writing zero selects standby, registers stay accessible.
// - Wake-timer bit selects sleep with wake timer.
// - Sensor mode runs battery detector, temperature sensor.
// - Crystal-on bit selects ready, crystal kept running.
// - Synthesizer-on selects tune, crystal enabled automatically.
// - Sequencer order: regulators, crystal, PLL, calibration, settle, receive; code turns PLL on with calibration, or at settle when calibration is skipped.
// - Calibration skipped when bit clear; resets set.
// - Device status reports FIFO, errors, power state.
// - Interrupt output low on any enabled event.
// - Interrupt held until status read, then released.
// - Status read clears its enabled bits.
// - Disabled events readable but never raise interrupt.
// - Frame: direction bit, 7-bit address, 8 data.
// - Held select auto-increments address every byte.
`timescale 1ns/100ps
`include "rmc_regs.vh"
module rmc_mode_ctrl #(
  parameter POR_CYC    = `RMC_POR_US * `RMC_CLK_MHZ,
  parameter XTAL_CYC   = `RMC_XTAL_US * `RMC_CLK_MHZ,
  parameter CAL_CYC    = `RMC_CAL_US * `RMC_CLK_MHZ,
  parameter SETTLE_CYC = `RMC_SETTLE_US * `RMC_CLK_MHZ
) (
  input  wire       clk,
  input  wire       sys_rst,
  input  wire       powerDownPin,
  input  wire       serialSelectN,
  input  wire       spiSclk,
  input  wire       spiSdi,
  output wire       spiSdo,
  output wire       spiSdoOe,
  input  wire [7:0] evtStatus1In,
  input  wire [7:0] evtStatus2In,
  input  wire [4:0] devFlagsIn,
  output reg        irqOutN,
  output reg        lowPowerRegulatorOn,
  output reg        mainRegulatorOn,
  output reg        analogRegulatorOn,
  output reg        xtalOn,
  output reg        pllOn,
  output reg        vcoCalOn,
  output reg        rxCircuitsOn,
  output reg        modemRxOn,
  output reg        wakeTimerOn,
  output reg        batteryDetectOn,
  output reg        tempSensorOn,
  output reg  [1:0] chipPowerState
);
  localparam [8:0] S_SHUT   = 9'h001;
  localparam [8:0] S_POR    = 9'h002;
  localparam [8:0] S_IDLE   = 9'h004;
  localparam [8:0] S_REG    = 9'h008;
  localparam [8:0] S_XTAL   = 9'h010;
  localparam [8:0] S_CAL    = 9'h020;
  localparam [8:0] S_SETTLE = 9'h040;
  localparam [8:0] S_RXEN   = 9'h080;
  localparam [8:0] S_RX     = 9'h100;

  wire        pdnS;
  wire        selNS;
  wire        sclkS;
  wire        sdiS;
  wire [6:0]  rdAddr;
  wire        rdStb;
  wire        wrStb;
  wire [6:0]  wrAddr;
  wire [7:0]  wrData;
  reg  [7:0]  rdData;
  reg         pdnDlyFf;
  reg  [8:0]  stateFf;
  reg  [8:0]  nxt_state;
  reg  [31:0] tmrFf;
  reg  [31:0] tmrLim;
  reg  [31:0] xtCntFf;
  reg         xtRdyFf;
  reg  [7:0]  en1Ff;
  reg  [7:0]  en2Ff;
  reg  [7:0]  modeFf;
  reg  [7:0]  mode2Ff;
  reg  [7:0]  xtalCtlFf;
  reg  [7:0]  st1Ff;
  reg  [7:0]  st2Ff;
  reg         porAckFf;

  rmc_sync #(
    .W       (4),
    .RST_VAL (4'h4)
  ) u_sync (
    .clk     (clk),
    .sys_rst (sys_rst),
    .din     ({powerDownPin, serialSelectN, spiSclk, spiSdi}),
    .dout    ({pdnS, selNS, sclkS, sdiS})
  );

  wire inShut = stateFf[0];
  wire inPor  = stateFf[1];
  wire inIdle = stateFf[2];
  wire live   = ~inShut & ~inPor;
  // Serial port is held in reset while shut down or in power-on reset.
  wire spiRst = sys_rst | ~live;

  rmc_spi_slave u_spi (
    .clk    (clk),
    .rst    (spiRst),
    .sclkS  (sclkS),
    .sdiS   (sdiS),
    .selNS  (selNS),
    .rdData (rdData),
    .rdAddr (rdAddr),
    .rdStb  (rdStb),
    .wrStb  (wrStb),
    .wrAddr (wrAddr),
    .wrData (wrData),
    .sdo    (spiSdo),
    .sdoOe  (spiSdoOe)
  );

  wire pdnFall = pdnDlyFf & ~pdnS;
  wire tmrDone = (tmrFf == tmrLim - 32'h0000_0001);
  wire porDone = inPor & tmrDone & ~pdnS;
  wire softRst = wrStb & (wrAddr == `RMC_ADDR_MODE) & wrData[`RMC_MODE_SWRES];
  // Register contents are lost in shutdown and rebuilt during power-on reset.
  wire regRst  = sys_rst | ~live | softRst;

  wire rxReq     = modeFf[`RMC_MODE_RXON];
  wire tuneSel   = modeFf[`RMC_MODE_PLLON];
  wire readySel  = ~tuneSel & modeFf[`RMC_MODE_XTON];
  wire senseReq  = modeFf[`RMC_MODE_ENLBD] | mode2Ff[`RMC_MODE2_ENTEMP];
  wire sensorSel = ~tuneSel & ~readySel & senseReq;
  wire sleepSel  = ~tuneSel & ~readySel & ~senseReq & modeFf[`RMC_MODE_ENWT];
  wire stbySel   = ~tuneSel & ~readySel & ~senseReq & ~modeFf[`RMC_MODE_ENWT];
  // Until the status is read after power-on reset, low-power sub-modes keep
  // the main regulator running.
  // A set buffer override keeps the crystal up, so it keeps the main regulator too.
  wire lpMode    = inIdle & porAckFf & (stbySel | sleepSel) & ~xtalCtlFf[`RMC_XTAL_BUFOVR];
  wire seqBusy   = live & ~inIdle;
  // Override holds the crystal on, so leaving ready does not stop it until it is cleared.
  wire xtalWant  = live & (tuneSel | readySel | xtalCtlFf[`RMC_XTAL_BUFOVR] | seqBusy);
  wire pllWant   = (inIdle & tuneSel) | (|stateFf[8:5]);
  wire xtHit     = xtalWant & ~xtRdyFf & (xtCntFf == XTAL_CYC - 1);

  always @* begin
    case (stateFf)
      S_POR:    tmrLim = POR_CYC;
      S_CAL:    tmrLim = CAL_CYC;
      S_SETTLE: tmrLim = SETTLE_CYC;
      default:  tmrLim = 32'h0000_0001;
    endcase
  end

  // A warm crystal from ready or tune skips the start-up wait.
  always @* begin
    nxt_state = stateFf;
    case (stateFf)
      S_SHUT:   if (pdnFall) nxt_state = S_POR;
      S_POR:    if (tmrDone) nxt_state = S_IDLE;
      S_IDLE:   if (rxReq) nxt_state = S_REG;
      S_REG:    nxt_state = S_XTAL;
      S_XTAL: begin
        if (xtRdyFf) begin
          nxt_state = mode2Ff[`RMC_MODE2_VCOCAL] ? S_CAL : S_SETTLE;
        end
      end
      S_CAL:    if (tmrDone) nxt_state = S_SETTLE;
      S_SETTLE: if (tmrDone) nxt_state = S_RXEN;
      S_RXEN:   nxt_state = S_RX;
      S_RX:     nxt_state = S_RX;
      default:  nxt_state = S_POR;
    endcase
    if (seqBusy & ~rxReq) begin
      nxt_state = S_IDLE;
    end
    if (softRst) begin
      nxt_state = S_IDLE;
    end
    if (pdnS) begin
      nxt_state = S_SHUT;
    end
  end

  always @(posedge clk) begin
    if (sys_rst) begin
      stateFf  <= S_POR;
      tmrFf    <= 32'h0000_0000;
      pdnDlyFf <= 1'b0;
      xtCntFf  <= 32'h0000_0000;
      xtRdyFf  <= 1'b0;
    end else begin
      stateFf  <= nxt_state;
      tmrFf    <= (nxt_state != stateFf) ? 32'h0000_0000 : tmrFf + 32'h0000_0001;
      pdnDlyFf <= pdnS;
      if (~xtalWant) begin
        xtCntFf <= 32'h0000_0000;
        xtRdyFf <= 1'b0;
      end else if (xtHit) begin
        xtRdyFf <= 1'b1;
      end else if (~xtRdyFf) begin
        xtCntFf <= xtCntFf + 32'h0000_0001;
      end
    end
  end

  // Writable registers; the mode register steers the sequencer.
  always @(posedge clk) begin
    if (regRst) begin
      en1Ff     <= `RMC_RST_IRQ_EN1;
      en2Ff     <= `RMC_RST_IRQ_EN2;
      modeFf    <= `RMC_RST_MODE;
      mode2Ff   <= `RMC_RST_MODE2;
      xtalCtlFf <= `RMC_RST_XTAL_CTL;
    end else if (wrStb) begin
      case (wrAddr)
        `RMC_ADDR_IRQ_EN1:  en1Ff     <= wrData & `RMC_IRQ1_MASK;
        `RMC_ADDR_IRQ_EN2:  en2Ff     <= wrData;
        `RMC_ADDR_MODE:     modeFf    <= wrData & `RMC_MODE_WMASK;
        `RMC_ADDR_MODE2:    mode2Ff   <= wrData & `RMC_MODE2_WMASK;
        `RMC_ADDR_XTAL_CTL: xtalCtlFf <= wrData;
        default:            en1Ff     <= en1Ff;
      endcase
    end
  end

  always @* begin
    rdData = 8'h00;
    case (rdAddr)
      `RMC_ADDR_DEV_STATUS: rdData = {devFlagsIn, 1'b0, chipPowerState};
      `RMC_ADDR_IRQ_ST1:    rdData = st1Ff;
      `RMC_ADDR_IRQ_ST2:    rdData = st2Ff;
      `RMC_ADDR_IRQ_EN1:    rdData = en1Ff;
      `RMC_ADDR_IRQ_EN2:    rdData = en2Ff;
      `RMC_ADDR_MODE:       rdData = modeFf;
      `RMC_ADDR_MODE2:      rdData = mode2Ff;
      `RMC_ADDR_XTAL_CTL:   rdData = xtalCtlFf;
      default:              rdData = 8'h00;
    endcase
  end

  wire       rd1   = rdStb & (rdAddr == `RMC_ADDR_IRQ_ST1);
  wire       rd2   = rdStb & (rdAddr == `RMC_ADDR_IRQ_ST2);
  wire [7:0] set1  = evtStatus1In & `RMC_IRQ1_MASK & {8{live}};
  wire [7:0] set2  = {evtStatus2In[7:2] & {6{live}}, xtHit & live, porDone};
  wire [7:0] base1 = regRst ? 8'h00 : st1Ff;
  wire [7:0] base2 = regRst ? 8'h00 : st2Ff;
  wire [7:0] clr1  = rd1 ? en1Ff : 8'h00;
  wire [7:0] clr2  = rd2 ? en2Ff : 8'h00;
  wire       irqHit = |((st1Ff & en1Ff) | (st2Ff & en2Ff));

  // A new event in the cycle of its read-clear stays set.
  always @(posedge clk) begin
    if (sys_rst) begin
      st1Ff    <= 8'h00;
      st2Ff    <= 8'h00;
      porAckFf <= 1'b0;
      irqOutN  <= 1'b1;
    end else begin
      st1Ff    <= (base1 & ~clr1) | set1;
      st2Ff    <= (base2 & ~clr2) | set2;
      porAckFf <= live & (porAckFf | rd2);
      irqOutN  <= ~irqHit;
    end
  end

  always @(posedge clk) begin
    if (sys_rst) begin
      lowPowerRegulatorOn <= 1'b0;
      mainRegulatorOn     <= 1'b0;
      analogRegulatorOn   <= 1'b0;
      xtalOn              <= 1'b0;
      pllOn               <= 1'b0;
      vcoCalOn            <= 1'b0;
      rxCircuitsOn        <= 1'b0;
      modemRxOn           <= 1'b0;
      wakeTimerOn         <= 1'b0;
      batteryDetectOn     <= 1'b0;
      tempSensorOn        <= 1'b0;
      chipPowerState      <= `RMC_CPS_IDLE;
    end else begin
      lowPowerRegulatorOn <= ~inShut;
      mainRegulatorOn     <= ~inShut & ~lpMode;
      analogRegulatorOn   <= seqBusy;
      xtalOn              <= xtalWant;
      pllOn               <= pllWant;
      vcoCalOn            <= stateFf[5];
      rxCircuitsOn        <= |stateFf[8:7];
      modemRxOn           <= stateFf[8];
      wakeTimerOn         <= live & (modeFf[`RMC_MODE_ENWT] | senseReq);
      batteryDetectOn     <= live & modeFf[`RMC_MODE_ENLBD];
      tempSensorOn        <= live & mode2Ff[`RMC_MODE2_ENTEMP];
      chipPowerState      <= stateFf[8] ? `RMC_CPS_RX : `RMC_CPS_IDLE;
    end
  end
endmodule // rmc_mode_ctrl

//--- rmc_mode_ctrl_monitor.sv
// Concurrent checks on the ports of the mode controller.
`timescale 1ns/100ps
module rmc_mode_ctrl_monitor (
  input wire       clk,
  input wire       sys_rst,
  input wire       powerDownPin,
  input wire       serialSelectN,
  input wire       spiSdo,
  input wire       spiSdoOe,
  input wire       irqOutN,
  input wire       lowPowerRegulatorOn,
  input wire       mainRegulatorOn,
  input wire       xtalOn,
  input wire       pllOn,
  input wire       rxCircuitsOn,
  input wire       modemRxOn,
  input wire [1:0] chipPowerState
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // Six cycles cover the pin synchroniser, the state change and the output register.
  a_shut_quiet: assert property (
    powerDownPin [*6] |-> !spiSdoOe && !mainRegulatorOn) else $error("active in shutdown");
  a_lowpwr_on: assert property (
    !powerDownPin [*6] |-> lowPowerRegulatorOn) else $error("low power regulator off");
  a_rx_supply: assert property (
    modemRxOn |-> mainRegulatorOn && xtalOn && pllOn) else $error("receive without supply");
  a_rx_order: assert property (
    $rose(modemRxOn) |-> $past(rxCircuitsOn)) else $error("modem before receive circuits");
  a_settle_gap: assert property (
    $rose(rxCircuitsOn) |-> $past(pllOn, 3)) else $error("no settling before receive");
  a_tune_xtal: assert property (
    pllOn |-> xtalOn) else $error("synthesizer without crystal");
  a_low_main: assert property (
    !mainRegulatorOn |-> !xtalOn && !pllOn) else $error("crystal on main regulator off");
  a_cps_rx: assert property (
    modemRxOn |-> chipPowerState == 2'h1) else $error("power state not receive");
  // A read clears the flag inside the frame, so an idle port must leave the line low.
  a_irq_hold: assert property (
    !irqOutN && serialSelectN && $past(serialSelectN, 4) && !powerDownPin |=> !irqOutN)
    else $error("interrupt released without read");
  a_sdo_idle: assert property (
    serialSelectN [*6] |-> spiSdo) else $error("serial out not high when idle");
endmodule // rmc_mode_ctrl_monitor

//--- rmc_host_model.sv
// Host side model: serial register frames and the power-down pin.
`timescale 1ns/100ps
module rmc_host_model (
  input  wire        clk,
  input  wire        spiSdo,
  output logic       powerDownPin,
  output logic       serialSelectN,
  output logic       spiSclk,
  output logic       spiSdi,
  output logic       rdStb,
  output logic [7:0] rdByte
);
  initial begin
    powerDownPin = 1'b0;
    serialSelectN = 1'b1;
    spiSclk = 1'b0;
    spiSdi = 1'b1;
    rdStb = 1'b0;
    rdByte = 8'h00;
  end
  task automatic pin(input logic v);
    @(negedge clk);
    powerDownPin = v;
  endtask
  // Half a serial period is eight clocks; the link clock stands low between frames.
  task automatic xfer(input logic wr, input logic [6:0] a, input logic [31:0] d, input int nb);
    logic [39:0] sh;
    sh = {wr, a, d};
    @(negedge clk);
    serialSelectN = 1'b0;
    for (int i = 0; i < 8 * (nb + 1); i++) begin
      @(negedge clk);
      rdStb = 1'b0;
      repeat (7) @(negedge clk);
      spiSclk = 1'b0;
      spiSdi = sh[39-i];
      repeat (8) @(negedge clk);
      spiSclk = 1'b1;
      if (!wr && i >= 8) begin
        rdByte = {rdByte[6:0], spiSdo};
        rdStb = (i % 8 == 7);
      end
    end
    @(negedge clk);
    rdStb = 1'b0;
    repeat (7) @(negedge clk);
    spiSclk = 1'b0;
    spiSdi = ~spiSdi;
    repeat (8) @(negedge clk);
    serialSelectN = 1'b1;
    repeat (8) @(negedge clk);
  endtask
endmodule // rmc_host_model

//--- rmc_mode_ctrl_tb.sv
// Self-checking bench for the mode controller.
`timescale 1ns/100ps
module rmc_mode_ctrl_tb;
  localparam int POR = 50, XT = 60, CAL = 5, ST = 5;
  logic       clk, sys_rst, chkStb, sclkQ, rxQ, calSeen;
  logic [7:0] evtStatus1In, evtStatus2In, chkVal, r;
  logic [4:0] devFlagsIn;
  int         nErrors = 0, nCompared = 0, since = 0, rxLat = 0, n;
  logic [7:0] q[$];
  wire        powerDownPin, serialSelectN, spiSclk, spiSdi, spiSdo, spiSdoOe, rdStb;
  wire        irqOutN, lowPowerRegulatorOn, mainRegulatorOn, analogRegulatorOn, xtalOn;
  wire        pllOn, vcoCalOn, rxCircuitsOn, modemRxOn, wakeTimerOn, batteryDetectOn;
  wire        tempSensorOn;
  wire [1:0]  chipPowerState;
  wire [7:0]  rdByte;
  logic [7:0] mv[5] = '{8'h00, 8'h40, 8'h60, 8'h01, 8'h02};
  logic [4:0] pv[5] = '{5'h00, 5'h10, 5'h19, 5'h0c, 5'h0e};
  rmc_mode_ctrl #(.POR_CYC(POR), .XTAL_CYC(XT), .CAL_CYC(CAL), .SETTLE_CYC(ST))
    rmc_mode_ctrl_inst (
      .clk                 (clk),
      .sys_rst             (sys_rst),
      .powerDownPin        (powerDownPin),
      .serialSelectN       (serialSelectN),
      .spiSclk             (spiSclk),
      .spiSdi              (spiSdi),
      .spiSdo              (spiSdo),
      .spiSdoOe            (spiSdoOe),
      .evtStatus1In        (evtStatus1In),
      .evtStatus2In        (evtStatus2In),
      .devFlagsIn          (devFlagsIn),
      .irqOutN             (irqOutN),
      .lowPowerRegulatorOn (lowPowerRegulatorOn),
      .mainRegulatorOn     (mainRegulatorOn),
      .analogRegulatorOn   (analogRegulatorOn),
      .xtalOn              (xtalOn),
      .pllOn               (pllOn),
      .vcoCalOn            (vcoCalOn),
      .rxCircuitsOn        (rxCircuitsOn),
      .modemRxOn           (modemRxOn),
      .wakeTimerOn         (wakeTimerOn),
      .batteryDetectOn     (batteryDetectOn),
      .tempSensorOn        (tempSensorOn),
      .chipPowerState      (chipPowerState)
    );
  rmc_host_model hostModel (
    .clk           (clk),
    .spiSdo        (spiSdo),
    .powerDownPin  (powerDownPin),
    .serialSelectN (serialSelectN),
    .spiSclk       (spiSclk),
    .spiSdi        (spiSdi),
    .rdStb         (rdStb),
    .rdByte        (rdByte)
  );
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Latency is counted from the last rising link clock edge of the frame.
  always @(posedge clk) begin
    sclkQ <= spiSclk;
    rxQ <= modemRxOn;
    since <= (spiSclk & ~sclkQ) ? 0 : since + 1;
    if (modemRxOn & ~rxQ) rxLat <= since;
    if (vcoCalOn) calSeen <= 1'b1;
  end
  always @(posedge clk) if (rdStb || chkStb) begin
    nCompared++;
    if (q.size() == 0 || (rdStb ? rdByte : chkVal) !== q[0]) begin
      nErrors++;
      $display("Error at %0t: got %h expected %h", $time, rdStb ? rdByte : chkVal, q[0]);
    end
    if (q.size() > 0) void'(q.pop_front());
  end
  task automatic lvl(input logic [7:0] v, input logic [7:0] e);
    q.push_back(e);
    chkVal = v;
    chkStb = 1'b1;
    @(negedge clk);
    chkStb = 1'b0;
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    hostModel.xfer(1'b1, a, {d, 24'h0000_0000}, 1);
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] e);
    q.push_back(e);
    hostModel.xfer(1'b0, a, 32'h0000_0000, 1);
  endtask
  task automatic rxWait;
    n = 0;
    while (!modemRxOn && n < 1000) begin
      @(negedge clk);
      n++;
    end
    repeat (2) @(negedge clk);
  endtask
  task automatic reportAndStop;
    $display("Compared %0d, mismatches %0d", nCompared, nErrors);
    if (nErrors == 0 && nCompared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge clk);
    nErrors++;
    reportAndStop;
  end
  initial begin
    sys_rst = 1'b1;
    chkStb = 1'b0;
    chkVal = 8'h00;
    calSeen = 1'b0;
    evtStatus1In = 8'h00;
    evtStatus2In = 8'h00;
    devFlagsIn = 5'h00;
    r = $urandom(32'h4d7f);
    repeat (4) @(negedge clk);
    sys_rst = 1'b0;
    repeat (POR + 10) @(negedge clk);
    q = '{8'h00, 8'h01, 8'h01, 8'h01};
    hostModel.xfer(1'b0, 7'h05, 32'h0000_0000, 4);
    lvl(irqOutN, 8'h00);
    rd(7'h04, 8'h03);
    lvl(irqOutN, 8'h01);
    rd(7'h04, 8'h02);
    $display("Reset and power-on test done");
    wr(7'h05, 8'h08);
    r = $urandom | 8'h08;
    evtStatus1In = r;
    evtStatus2In = $urandom;
    @(negedge clk);
    evtStatus1In = 8'h00;
    evtStatus2In = 8'h00;
    repeat (3) @(negedge clk);
    lvl(irqOutN, 8'h00);
    rd(7'h03, r & 8'h99);
    lvl(irqOutN, 8'h01);
    rd(7'h03, r & 8'h91);
    devFlagsIn = $urandom;
    rd(7'h02, {devFlagsIn, 3'h0});
    $display("Interrupt test done");
    for (int i = 0; i < 5; i++) begin
      wr(7'h07, mv[i]);
      rd(7'h07, mv[i]);
      lvl({3'h0, wakeTimerOn, mainRegulatorOn, xtalOn, pllOn, batteryDetectOn}, pv[i]);
    end
    $display("Idle mode test done");
    wr(7'h07, 8'h01);
    calSeen = 1'b0;
    rxLat = 0;
    wr(7'h07, 8'h05);
    rxWait;
    lvl(rxLat >= CAL + ST && rxLat < XT, 8'h01);
    lvl(calSeen, 8'h01);
    rd(7'h02, {devFlagsIn, 3'h1});
    wr(7'h07, 8'h00);
    wr(7'h08, 8'h00);
    calSeen = 1'b0;
    rxLat = 0;
    wr(7'h07, 8'h04);
    rxWait;
    lvl(rxLat >= XT && rxLat < XT + 30, 8'h01);
    lvl(calSeen, 8'h00);
    $display("Receive sequence test done");
    wr(7'h07, 8'h80);
    q.push_back(8'h00);
    q.push_back(8'h01);
    q.push_back(8'h01);
    q.push_back(8'h01);
    hostModel.xfer(1'b0, 7'h05, 32'h0000_0000, 4);
    hostModel.pin(1'b1);
    repeat (10) @(negedge clk);
    lvl(spiSdoOe, 8'h00);
    wr(7'h05, 8'hff);
    hostModel.pin(1'b0);
    repeat (POR + 10) @(negedge clk);
    lvl(irqOutN, 8'h00);
    rd(7'h05, 8'h00);
    rd(7'h07, 8'h01);
    $display("Shutdown test done");
    repeat (2) @(negedge clk);
    nErrors += q.size();
    reportAndStop;
  end
endmodule // rmc_mode_ctrl_tb
bind rmc_mode_ctrl rmc_mode_ctrl_monitor rmc_mode_ctrl_monitor_inst (
  .clk                 (clk),
  .sys_rst             (sys_rst),
  .powerDownPin        (powerDownPin),
  .serialSelectN       (serialSelectN),
  .spiSdo              (spiSdo),
  .spiSdoOe            (spiSdoOe),
  .irqOutN             (irqOutN),
  .lowPowerRegulatorOn (lowPowerRegulatorOn),
  .mainRegulatorOn     (mainRegulatorOn),
  .xtalOn              (xtalOn),
  .pllOn               (pllOn),
  .rxCircuitsOn        (rxCircuitsOn),
  .modemRxOn           (modemRxOn),
  .chipPowerState      (chipPowerState)
);
